// ===== core/qti_top.sv
// Purpose: Four 16-bit timers with their internal wiring, infrared modulator,
//          register port and interrupt logic.
// Assumes: Count clocks and capture inputs are synchronous levels; a count
//          tick is a rising edge of the selected source.
// Notes:   Summary of operation follows.
`timescale 1ns/1ns

module qti_timer #(
    parameter int unsigned NCH = 3,
    parameter int unsigned W   = 16
) (
    // Clock and reset.
    input  wire logic                        clk_i,
    input  wire logic                        nrst_i,
    // Configuration, count sources and capture inputs.
    input  wire logic [qti_pkg::CTL_W-1:0]   ctl_i,
    input  wire logic [2:0]                  clk_src_i,
    input  wire logic [NCH-1:0]              cci_a_i,
    input  wire logic [NCH-1:0]              cci_b_i,
    // Software writes.
    input  wire logic                        cnt_wr_i,
    input  wire logic [NCH-1:0]              ccr_wr_i,
    input  wire logic [W-1:0]                wdata_i,
    // State and events.
    output logic      [W-1:0]                cnt_o,
    output logic      [NCH-1:0][W-1:0]       ccr_o,
    output logic      [NCH-1:0]              out_o,
    output logic                             ovf_o,
    output logic      [NCH-1:0]              ccev_o
);
    import qti_pkg::*;

    typedef struct packed {
        logic [W-1:0]          cnt;
        logic [NCH-1:0][W-1:0] ccr;
        logic [NCH-1:0]        out;
        logic [NCH-1:0]        cap_prev;
        logic                  tick_prev;
        logic                  ovf;
        logic [NCH-1:0]        ccev;
    } qti_tmr_t;

    qti_tmr_t q, d;

    // Only two or three channels are wired in this device.
    if (NCH < 2 || NCH > CH_MAX) begin : g_chk
        $error("qti_timer: NCH must be 2 or 3");
    end

    // Counter, compare and capture logic.
    always_comb begin
        logic [1:0]            mode;
        logic [1:0]            csel;
        logic                  src;
        logic                  tick;
        logic                  wrap;
        logic [W-1:0]          top;
        logic [CH_FIELD_W-1:0] fld;
        logic                  cin;
        // Every temporary starts from a known value, so no path can infer a latch.
        src = 1'b0;
        fld = '0;
        cin = 1'b0;
        tick = 1'b0;
        wrap = 1'b0;
        top = '0;
        mode = ctl_i[CTL_MODE_LSB +: 2];
        csel = ctl_i[CTL_CLK_LSB +: 2];
        d = q;
        d.ovf = 1'b0;
        d.ccev = '0;
        unique case (csel)
            CLK_EXT: src = clk_src_i[0];
            CLK_AUX: src = clk_src_i[1];
            CLK_SUB: src = clk_src_i[2];
            default: src = 1'b0;
        endcase
        d.tick_prev = src;
        tick = src && !q.tick_prev && (mode == MODE_UP || mode == MODE_CONT);
        // In up mode the period register bounds the count; >= keeps a lowered
        // period from letting the counter run to full scale.
        top = (mode == MODE_UP) ? q.ccr[0] : '1;
        wrap = tick && (q.cnt >= top);
        if (tick) begin
            d.cnt = wrap ? '0 : q.cnt + W'(1);
        end
        d.ovf = wrap;
        for (int i = 0; i < NCH; i++) begin
            fld = ctl_i[CTL_CH_LSB + CH_FIELD_W * i +: CH_FIELD_W];
            unique case (fld[CH_SEL_LSB +: 2])
                SEL_A:   cin = cci_a_i[i];
                SEL_B:   cin = cci_b_i[i];
                SEL_GND: cin = 1'b0;
                default: cin = 1'b1;
            endcase
            d.cap_prev[i] = cin;
            if (fld[CH_CAP]) begin
                if (cin && !q.cap_prev[i]) begin
                    d.ccr[i] = q.cnt;
                    d.ccev[i] = 1'b1;
                end
            end else begin
                if (tick && q.cnt == q.ccr[i]) begin
                    d.ccev[i] = 1'b1;
                    if (fld[CH_OMODE]) begin
                        d.out[i] = 1'b0;
                    end
                end
                // Reset/set PWM: wrap sets the output after any compare reset.
                if (fld[CH_OMODE] && wrap) begin
                    d.out[i] = 1'b1;
                end
            end
            if (!fld[CH_OMODE]) begin
                d.out[i] = fld[CH_OBIT];
            end
            if (ccr_wr_i[i]) begin
                d.ccr[i] = wdata_i;
            end
        end
        if (cnt_wr_i) begin
            d.cnt = '0;
        end
    end

    // State register.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign cnt_o  = q.cnt;
    assign ccr_o  = q.ccr;
    assign out_o  = q.out;
    assign ovf_o  = q.ovf;
    assign ccev_o = q.ccev;
endmodule

module qti_top (
    // Clock and reset.
    input  wire logic                          SYS_CLK_I,
    input  wire logic                          NRST_I,
    // Register port.
    input  wire logic [qti_pkg::ADDR_W-1:0]    ADDR_I,
    input  wire logic [qti_pkg::DATA_W-1:0]    WDATA_I,
    input  wire logic                          WR_I,
    input  wire logic                          RD_I,
    output logic      [qti_pkg::DATA_W-1:0]    RDATA_O,
    // Count clock sources.
    input  wire logic                          EXT_TIMER_CLOCK0_I,
    input  wire logic                          EXT_TIMER_CLOCK1_I,
    input  wire logic                          AUX_CLOCK_I,
    input  wire logic                          SUB_MAIN_CLOCK_I,
    // Capture pins and internal sources.
    input  wire logic [1:0]                    T0_CAP_PIN_I,
    input  wire logic [1:0]                    T1_CAP_PIN_I,
    input  wire logic                          RTC_EVT_I,
    input  wire logic                          SERIAL_TX_DATA_I,
    // Pin and internal outputs.
    output logic      [1:0]                    T0_PWM_O,
    output logic      [1:0]                    T1_PWM_O,
    output logic                               ADC_TRIG_O,
    output logic                               SERIAL_TX_PIN_O,
    output logic                               IRQ_O
);
    import qti_pkg::*;

    typedef struct packed {
        logic [TMR_NUM-1:0][CTL_W-1:0] ctl;
        logic [IR_W-1:0]               ir;
        logic [STAT_W-1:0]             stat;
        logic [STAT_W-1:0]             en;
        logic [DATA_W-1:0]             rdata;
        logic                          irq;
        logic                          tx_pin;
    } qti_top_t;

    qti_top_t q, d;

    wire [TMR_NUM-1:0][CH_MAX-1:0][QTI_W-1:0] ccr_all;
    wire [TMR_NUM-1:0][QTI_W-1:0]             cnt_all;
    wire [TMR_NUM-1:0][CH_MAX-1:0]            out_all;
    wire [TMR_NUM-1:0][CH_MAX-1:0]            ccev_all;
    wire [TMR_NUM-1:0]                        ovf_all;
    wire [TMR_NUM-1:0][CH_MAX-1:0]            cci_a;
    wire [TMR_NUM-1:0][CH_MAX-1:0]            cci_b;
    wire [TMR_NUM-1:0]                        ext_clk;
    logic [TMR_NUM-1:0]                       cnt_wr;
    logic [TMR_NUM-1:0][CH_MAX-1:0]           ccr_wr;

    // Channel zero never sees a pin; the two-channel timers see no pin at all.
    assign cci_a[0] = {T0_CAP_PIN_I, 1'b0};
    assign cci_a[1] = {T1_CAP_PIN_I, 1'b0};
    assign cci_a[2] = 3'h0;
    assign cci_a[3] = 3'h0;
    assign cci_b[0] = {1'b0, RTC_EVT_I, 1'b0};
    assign cci_b[1] = out_all[0];
    assign cci_b[2] = 3'h0;
    assign cci_b[3] = {1'b0, out_all[2][1:0]};
    // External pin clocks reach only the three-channel timers.
    assign ext_clk  = {1'b0, 1'b0, EXT_TIMER_CLOCK1_I, EXT_TIMER_CLOCK0_I};

    // Four timers; instances 0 and 1 carry three channels, 2 and 3 carry two.
    for (genvar t = 0; t < TMR_NUM; t++) begin : g_tmr
        localparam int unsigned N = (t < 2) ? 3 : 2;
        qti_timer #(.NCH(N), .W(QTI_W)) u_tmr (
            .clk_i     (SYS_CLK_I),
            .nrst_i    (NRST_I),
            .ctl_i     (q.ctl[t]),
            .clk_src_i ({SUB_MAIN_CLOCK_I, AUX_CLOCK_I, ext_clk[t]}),
            .cci_a_i   (cci_a[t][N-1:0]),
            .cci_b_i   (cci_b[t][N-1:0]),
            .cnt_wr_i  (cnt_wr[t]),
            .ccr_wr_i  (ccr_wr[t][N-1:0]),
            .wdata_i   (WDATA_I[QTI_W-1:0]),
            .cnt_o     (cnt_all[t]),
            .ccr_o     (ccr_all[t][N-1:0]),
            .out_o     (out_all[t][N-1:0]),
            .ovf_o     (ovf_all[t]),
            .ccev_o    (ccev_all[t][N-1:0])
        );
        if (N < CH_MAX) begin : g_pad
            assign ccr_all[t][CH_MAX-1]  = '0;
            assign out_all[t][CH_MAX-1]  = 1'b0;
            assign ccev_all[t][CH_MAX-1] = 1'b0;
        end
    end

    // Write decode toward the timers.
    always_comb begin
        logic [1:0] tsel;
        logic [4:0] roff;
        tsel = ADDR_I[6:5];
        roff = ADDR_I[4:0];
        cnt_wr = '0;
        ccr_wr = '0;
        if (WR_I && !ADDR_I[7]) begin
            cnt_wr[tsel] = (roff == OFS_CNT);
            ccr_wr[tsel][0] = (roff == OFS_PERIOD_COMPARE_REG);
            ccr_wr[tsel][1] = (roff == OFS_CCR1);
            ccr_wr[tsel][2] = (roff == OFS_CCR2);
        end
    end

    // Registers, events, interrupt and infrared modulator.
    always_comb begin
        logic [1:0]        tsel;
        logic [4:0]        roff;
        logic [STAT_W-1:0] ev;
        logic [STAT_W-1:0] clr;
        logic              data;
        logic              mod;
        tsel = ADDR_I[6:5];
        roff = ADDR_I[4:0];
        data = 1'b0;
        mod = 1'b0;
        d = q;
        d.rdata = '0;
        clr = '0;
        ev = '0;
        for (int t = 0; t < TMR_NUM; t++) begin
            ev[SLOT_W * t +: SLOT_W] = {ovf_all[t], ccev_all[t]};
        end
        if (WR_I) begin
            if (!ADDR_I[7]) begin
                if (roff == OFS_CTL) begin
                    d.ctl[tsel] = WDATA_I[CTL_W-1:0];
                end
            end else begin
                unique case (ADDR_I)
                    OFS_IR:  d.ir = WDATA_I[IR_W-1:0];
                    OFS_CLR: clr = WDATA_I[STAT_W-1:0];
                    OFS_EN:  d.en = WDATA_I[STAT_W-1:0];
                    default: d.ir = q.ir;
                endcase
            end
        end
        // A new event beats a clear written in the same cycle.
        d.stat = (q.stat & ~clr) | ev;
        d.irq = |(d.stat & d.en);
        if (RD_I) begin
            if (!ADDR_I[7]) begin
                unique case (roff)
                    OFS_CTL:  d.rdata = DATA_W'(q.ctl[tsel]);
                    OFS_CNT:  d.rdata = DATA_W'(cnt_all[tsel]);
                    OFS_PERIOD_COMPARE_REG: d.rdata = DATA_W'(ccr_all[tsel][0]);
                    OFS_CCR1: d.rdata = DATA_W'(ccr_all[tsel][1]);
                    OFS_CCR2: d.rdata = DATA_W'(ccr_all[tsel][2]);
                    default:  d.rdata = '0;
                endcase
            end else begin
                unique case (ADDR_I)
                    OFS_IR:   d.rdata = DATA_W'(q.ir);
                    OFS_STAT: d.rdata = DATA_W'(q.stat);
                    OFS_EN:   d.rdata = DATA_W'(q.en);
                    default:  d.rdata = '0;
                endcase
            end
        end
        // Data comes from the serial line or the software bit; ASK gates the
        // timer 0 carrier, FSK picks between the timer 0 and timer 1 carriers.
        data = q.ir[IR_DSEL] ? q.ir[IR_DATA] : SERIAL_TX_DATA_I;
        data = data ^ q.ir[IR_POL];
        mod = q.ir[IR_MODE] ? (data ? out_all[0][2] : out_all[1][2])
                            : (data & out_all[0][2]);
        d.tx_pin = q.ir[IR_EN] ? mod : SERIAL_TX_DATA_I;
    end

    // State register.
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            q.ctl    <= {TMR_NUM{CTL_RST}};
            q.ir     <= IR_RST;
            q.stat   <= '0;
            q.en     <= EN_RST;
            q.rdata  <= '0;
            q.irq    <= 1'b0;
            q.tx_pin <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign RDATA_O         = q.rdata;
    assign T0_PWM_O        = out_all[0][2:1];
    assign T1_PWM_O        = out_all[1][2:1];
    assign ADC_TRIG_O      = out_all[1][1];
    assign SERIAL_TX_PIN_O = q.tx_pin;
    assign IRQ_O           = q.irq;
endmodule

// ===== core/qti_pkg.sv
// Purpose: Shared constants of the quad timer interconnect block.
// Assumes: 32-bit register port, byte addresses on word boundaries.
// Notes:   Each timer owns a 32-byte window; system registers sit above them.
package qti_pkg;
    // Sizes.
    localparam int unsigned QTI_W     = 16;
    localparam int unsigned TMR_NUM   = 4;
    localparam int unsigned CH_MAX    = 3;
    localparam int unsigned ADDR_W    = 8;
    localparam int unsigned DATA_W    = 32;
    // Register offsets.
    localparam logic [4:0] OFS_CTL   = 5'h00;
    localparam logic [4:0] OFS_CNT   = 5'h04;
    localparam logic [4:0] OFS_PERIOD_COMPARE_REG  = 5'h08;
    localparam logic [4:0] OFS_CCR1  = 5'h0c;
    localparam logic [4:0] OFS_CCR2  = 5'h10;
    localparam logic [7:0] OFS_IR    = 8'h80;
    localparam logic [7:0] OFS_STAT  = 8'h84;
    localparam logic [7:0] OFS_CLR   = 8'h88;
    localparam logic [7:0] OFS_EN    = 8'h8c;
    // Timer control fields.
    localparam int unsigned CTL_MODE_LSB = 0;
    localparam int unsigned CTL_CLK_LSB  = 2;
    localparam int unsigned CTL_CH_LSB   = 4;
    localparam int unsigned CH_FIELD_W   = 5;
    localparam int unsigned CH_CAP       = 0;
    localparam int unsigned CH_SEL_LSB   = 1;
    localparam int unsigned CH_OMODE     = 3;
    localparam int unsigned CH_OBIT      = 4;
    localparam int unsigned CTL_W        = 19;
    // Count modes, clock sources and capture input selections.
    localparam logic [1:0] MODE_STOP = 2'h0;
    localparam logic [1:0] MODE_UP   = 2'h1;
    localparam logic [1:0] MODE_CONT = 2'h2;
    localparam logic [1:0] CLK_EXT   = 2'h0;
    localparam logic [1:0] CLK_AUX   = 2'h1;
    localparam logic [1:0] CLK_SUB   = 2'h2;
    localparam logic [1:0] SEL_A     = 2'h0;
    localparam logic [1:0] SEL_B     = 2'h1;
    localparam logic [1:0] SEL_GND   = 2'h2;
    localparam logic [1:0] SEL_VCC   = 2'h3;
    // Infrared control fields.
    localparam int unsigned IR_EN   = 0;
    localparam int unsigned IR_POL  = 1;
    localparam int unsigned IR_MODE = 2;
    localparam int unsigned IR_DSEL = 3;
    localparam int unsigned IR_DATA = 4;
    localparam int unsigned IR_W    = 5;
    // Event slots: channels in bits 0..2, overflow in bit 3 of each nibble.
    localparam int unsigned SLOT_W   = 4;
    localparam int unsigned SLOT_OVF = 3;
    localparam int unsigned STAT_W   = 16;
    // Reset values.
    localparam logic [CTL_W-1:0]  CTL_RST = 19'h00000;
    localparam logic [IR_W-1:0]   IR_RST  = 5'h00;
    localparam logic [STAT_W-1:0] EN_RST  = 16'h0000;
endpackage

// ===== tb/qti_top_monitor.sv
// Purpose: Port checker of the quad timer block.
// Assumes: One clock; NRST_I is asynchronous and active low.
// Notes:   Pins and the interrupt may only move shortly after a write or a source change; read data follow a read.
`timescale 1ns/1ns
module qti_top_monitor
    import qti_pkg::*;
(
    // Clock, reset and register port.
    input wire logic        SYS_CLK_I,
    input wire logic        NRST_I,
    input wire logic [7:0]  ADDR_I,
    input wire logic        WR_I,
    input wire logic        RD_I,
    input wire logic [31:0] RDATA_O,
    // Sources and pins.
    input wire logic        EXT_TIMER_CLOCK0_I,
    input wire logic        EXT_TIMER_CLOCK1_I,
    input wire logic        AUX_CLOCK_I,
    input wire logic        SUB_MAIN_CLOCK_I,
    input wire logic [1:0]  T0_CAP_PIN_I,
    input wire logic        SERIAL_TX_DATA_I,
    // Outputs.
    input wire logic [1:0]  T0_PWM_O,
    input wire logic [1:0]  T1_PWM_O,
    input wire logic        ADC_TRIG_O,
    input wire logic        SERIAL_TX_PIN_O,
    input wire logic        IRQ_O
);
    logic [6:0] src;
    logic [6:0] src_q;
    logic [3:0] age_q;
    // A change of any count source, a timer 0 capture pin or the serial data counts as a cause.
    assign src = {EXT_TIMER_CLOCK0_I, EXT_TIMER_CLOCK1_I, AUX_CLOCK_I,
                  SUB_MAIN_CLOCK_I, T0_CAP_PIN_I, SERIAL_TX_DATA_I};
    // Cycles since the last cause, saturating so it never wraps to young.
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            src_q <= '0;
            age_q <= '0;
        end else begin
            src_q <= src;
            age_q <= (WR_I || src != src_q) ? 4'h0 : age_q + {3'h0, age_q != 4'hf};
        end
    end
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!NRST_I);
    // Read data and interrupt timing against their causes.
    rd_idle_a: assert property (RDATA_O != '0 |-> $past(RD_I))
        else $error("read data without a read");
    unmapped_zero_a: assert property (RD_I && (ADDR_I == OFS_CLR || ADDR_I > 8'h8f) |=> RDATA_O == '0)
        else $error("unmapped or clear register read non-zero");
    irq_fall_a: assert property ($fell(IRQ_O) |-> $past(WR_I) || $past(WR_I, 2) || $past(WR_I, 3))
        else $error("interrupt dropped without a write");
    irq_rise_a: assert property ($rose(IRQ_O) |-> age_q < 4'hc)
        else $error("interrupt rose without a cause");
    // Pins move only as a result of counting, capture, serial data or software.
    pwm0_cause_a: assert property (!$stable(T0_PWM_O) |-> age_q < 4'hc)
        else $error("timer 0 pin moved without a cause");
    pwm1_cause_a: assert property (!$stable(T1_PWM_O) |-> age_q < 4'hc)
        else $error("timer 1 pin moved without a cause");
    adc_cause_a: assert property (!$stable(ADC_TRIG_O) |-> age_q < 4'hc)
        else $error("converter trigger moved without a cause");
    tx_cause_a: assert property (!$stable(SERIAL_TX_PIN_O) |-> age_q < 4'hc)
        else $error("serial pin moved without a cause");
endmodule
bind qti_top qti_top_monitor qti_top_monitor_i (.SYS_CLK_I(SYS_CLK_I), .NRST_I(NRST_I),
    .ADDR_I(ADDR_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .EXT_TIMER_CLOCK0_I(EXT_TIMER_CLOCK0_I), .EXT_TIMER_CLOCK1_I(EXT_TIMER_CLOCK1_I),
    .AUX_CLOCK_I(AUX_CLOCK_I), .SUB_MAIN_CLOCK_I(SUB_MAIN_CLOCK_I),
    .T0_CAP_PIN_I(T0_CAP_PIN_I), .SERIAL_TX_DATA_I(SERIAL_TX_DATA_I),
    .T0_PWM_O(T0_PWM_O), .T1_PWM_O(T1_PWM_O), .ADC_TRIG_O(ADC_TRIG_O),
    .SERIAL_TX_PIN_O(SERIAL_TX_PIN_O), .IRQ_O(IRQ_O));

// ===== tb/qti_far_model.sv
// Purpose: Far-side model of the count clock sources.
// Assumes: Sources are slow levels sampled by the system clock.
// Notes:   Index 0 and 1 are the pin clocks, 2 auxiliary, 3 sub-main.
`timescale 1ns/1ns
module qti_far_model (
    // Clock.
    input  wire logic       clk_i,
    // Count sources.
    output logic      [3:0] src_o
);
    // Idle sources stay low so that no stray edge is counted.
    initial src_o = 4'h0;
    // Sends n ticks on one source; a larger slow value stretches the gaps.
    task automatic tick(input int sel, input int n, input int slow);
        repeat (n) begin
            @(posedge clk_i);
            src_o[sel] <= 1'b1;
            repeat (2) @(posedge clk_i);
            src_o[sel] <= 1'b0;
            repeat (1 + slow) @(posedge clk_i);
        end
    endtask
endmodule

// ===== tb/tb_qti_top.sv
// Purpose: Self-checking bench of the quad timer block.
// Assumes: One-cycle strobes; read data stand in the cycle after the read.
// Notes:   Periods are tiny so the whole run is a few hundred cycles.
`timescale 1ns/1ns
module tb_qti_top;
    import qti_pkg::*;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  addr = '0;
    logic [31:0] wdata = '0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [1:0]  cap = '0;
    logic        txd = 1'b1;
    logic [3:0]  src;
    logic [31:0] rdata;
    logic [1:0]  pwm0;
    logic [1:0]  pwm1;
    logic        adc;
    logic        txpin;
    logic        irq;
    logic [7:0]  base;
    logic [31:0] exp;
    logic [1:0]  want;
    int          n_fail = 0;
    int          num_checks = 0;
    int          cyc = 0;
    logic [7:0]  ir_code [11] = '{8'h19, 8'h09, 8'h1b, 8'h0b, 8'h0d, 8'h1d, 8'h01,
                                  8'h00, 8'h19, 8'h1d, 8'h0d};
    logic [10:0] ir_want = 11'b10011111001;
    // 20 MHz system clock.
    always #25 clk = ~clk;
    qti_far_model qti_far_model_i (.clk_i(clk), .src_o(src));
    qti_top qti_top_i (.SYS_CLK_I(clk), .NRST_I(nrst), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .EXT_TIMER_CLOCK0_I(src[0]),
        .EXT_TIMER_CLOCK1_I(src[1]), .AUX_CLOCK_I(src[2]), .SUB_MAIN_CLOCK_I(src[3]),
        .T0_CAP_PIN_I(cap), .T1_CAP_PIN_I(2'h0), .RTC_EVT_I(1'b0), .SERIAL_TX_DATA_I(txd),
        .T0_PWM_O(pwm0), .T1_PWM_O(pwm1), .ADC_TRIG_O(adc), .SERIAL_TX_PIN_O(txpin),
        .IRQ_O(irq));
    // Compares one value and counts the outcome.
    task automatic chk(input logic [31:0] seen, input logic [31:0] good);
        num_checks++;
        if (seen !== good) begin
            n_fail++;
            $display("CHECK FAILED %0t: saw %h, wanted %h", $time, seen, good);
        end
    endtask
    // Waits n edges, then settles at the falling edge.
    task automatic pause(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read data are taken in the single cycle after the strobe.
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] good);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata, good);
    endtask
    task automatic close_out();
        $display("checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // A hang is cut short well beyond the expected run length.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            n_fail++;
            close_out();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        rd_chk(OFS_EN, 32'h0);
        rd_chk(8'h90, 32'h0);
        // With the modulator off the pin carries the serial data.
        for (int b = 0; b < 2; b++) begin
            @(posedge clk);
            txd <= b[0];
            pause(2);
            chk(txpin, b[0]);
        end
        // Up mode on every timer from its own source: five ticks wrap at three.
        for (int t = 0; t < 4; t++) begin
            base = 8'(t * 32);
            exp = (t < 2) ? 32'hf << (4 * t) : 32'hb << (4 * t);
            wr_reg(base + OFS_PERIOD_COMPARE_REG, 32'h0001_0003);
            rd_chk(base + OFS_PERIOD_COMPARE_REG, 32'h3);
            wr_reg(base + OFS_CTL, 32'(MODE_UP) | 32'((t < 2) ? CLK_EXT : 2'(t - 1)) << 2);
            qti_far_model_i.tick(t, 5, t);
            pause(3);
            rd_chk(base + OFS_CNT, 32'h1);
            rd_chk(OFS_STAT, exp);
            wr_reg(OFS_EN, exp);
            pause(3);
            chk(irq, 1'b1);
            wr_reg(OFS_EN, 32'h0);
            pause(3);
            chk(irq, 1'b0);
            wr_reg(OFS_EN, exp);
            wr_reg(OFS_CLR, exp);
            wr_reg(base + OFS_CTL, 32'h0);
            pause(3);
            chk(irq, 1'b0);
            rd_chk(OFS_STAT, 32'h0);
        end
        // Capture from the pin, then from a ground-to-supply selection change.
        wr_reg(OFS_CNT, 32'h0);
        wr_reg(OFS_CTL, 32'(MODE_CONT) | 32'(CLK_AUX) << 2 | 32'h1 << 9);
        qti_far_model_i.tick(2, 3, 0);
        @(posedge clk);
        cap <= 2'h1;
        pause(3);
        rd_chk(OFS_CCR1, 32'h3);
        qti_far_model_i.tick(2, 2, 0);
        wr_reg(OFS_CTL, 32'(MODE_CONT) | 32'(CLK_AUX) << 2 | 32'h5 << 9);
        wr_reg(OFS_CTL, 32'(MODE_CONT) | 32'(CLK_AUX) << 2 | 32'h7 << 9);
        pause(3);
        rd_chk(OFS_CCR1, 32'h5);
        wr_reg(OFS_CTL, 32'h0);
        wr_reg(OFS_CLR, 32'hffff);
        // Software output bit of each channel: only timers 0 and 1 reach pins.
        for (int t = 0; t < 4; t++)
            for (int c = 0; c < 3; c++) begin
                wr_reg(8'(t * 32), 32'h1 << (CTL_CH_LSB + CH_FIELD_W * c + CH_OBIT));
                pause(3);
                want = (c > 0) ? 2'(1 << (c - 1)) : 2'h0;
                chk(pwm0, (t == 0) ? want : 2'h0);
                chk(pwm1, (t == 1) ? want : 2'h0);
                chk(adc, t == 1 && c == 1);
                wr_reg(8'(t * 32), 32'h0);
            end
        // Modulator table: first channel 2 of both timers high, then timer 0 low.
        wr_reg(OFS_CTL, 32'h1 << 18);
        wr_reg(8'h20, 32'h1 << 18);
        for (int i = 0; i < 11; i++) begin
            if (i == 8) begin
                wr_reg(OFS_CTL, 32'h0);
            end
            wr_reg(OFS_IR, 32'(ir_code[i]));
            pause(3);
            chk(txpin, ir_want[i]);
        end
        // Reset/set PWM on timer 0 channel 1; its rise is captured by timer 1 input B.
        wr_reg(8'h2c, 32'hff);
        wr_reg(8'h20, 32'h3 << 9);
        wr_reg(OFS_PERIOD_COMPARE_REG, 32'h3);
        wr_reg(OFS_CCR1, 32'h1);
        wr_reg(OFS_CNT, 32'h0);
        wr_reg(OFS_CTL, 32'(MODE_UP) | 32'(CLK_AUX) << 2 | 32'h1 << 12);
        qti_far_model_i.tick(2, 4, 0);
        pause(3);
        chk(pwm0, 2'h1);
        rd_chk(8'h2c, 32'h1);
        qti_far_model_i.tick(2, 2, 0);
        pause(3);
        chk(pwm0, 2'h0);
        rd_chk(OFS_CNT, 32'h2);
        close_out();
    end
endmodule
